// ==== ssd_pkg.sv ====
// Package of constants and types for the sixteen-point single-shot driver.
package ssd_pkg;

   // Number of output points.
   localparam int NUM_POINTS = 16;

   // Clock period in picoseconds (250 MHz).
   localparam longint CLK_PERIOD_PS = 64'd4000;

   // Documented times in microseconds; the two recovery times in nanoseconds.
   localparam longint SHORT_MIN_US   = 64'd500;
   localparam longint SHORT_MAX_US   = 64'd80000;
   localparam longint LONG_MIN_US    = 64'd80000;
   localparam longint LONG_MAX_US    = 64'd2000000;
   localparam longint DEFAULT_US     = 64'd60000;
   localparam longint REC_SHORT_NS   = 64'd50000;
   localparam longint REC_LONG_NS    = 64'd2000000;

   // Counter width; covers two seconds at 250 MHz.
   localparam int CNT_W = 29;

   // Cycle counts derived from the times; least times round up.
   localparam longint SHORT_MIN_CYC = (SHORT_MIN_US * 64'd1000000 + CLK_PERIOD_PS - 64'd1)
                                      / CLK_PERIOD_PS;
   localparam longint SHORT_MAX_CYC = (SHORT_MAX_US * 64'd1000000) / CLK_PERIOD_PS;
   localparam longint LONG_MIN_CYC  = (LONG_MIN_US * 64'd1000000 + CLK_PERIOD_PS - 64'd1)
                                      / CLK_PERIOD_PS;
   localparam longint LONG_MAX_CYC  = (LONG_MAX_US * 64'd1000000) / CLK_PERIOD_PS;
   localparam longint DEFAULT_CYC   = (DEFAULT_US * 64'd1000000) / CLK_PERIOD_PS;
   localparam longint REC_SHORT_CYC = (REC_SHORT_NS * 64'd1000 + CLK_PERIOD_PS - 64'd1)
                                      / CLK_PERIOD_PS;
   localparam longint REC_LONG_CYC  = (REC_LONG_NS * 64'd1000 + CLK_PERIOD_PS - 64'd1)
                                      / CLK_PERIOD_PS;

   // Point phases, Gray coded along idle, pulse, recovery.
   typedef enum logic [1:0] {
      SSD_IDLE    = 2'b00,
      SSD_PULSE   = 2'b01,
      SSD_RECOVER = 2'b11
   } ssd_phase_t;

endpackage : ssd_pkg

// ==== ssd_point.sv ====
// One single-shot timer for one output point.
`timescale 1ns/1ps
module ssd_point
   import ssd_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 trigger,
   input  wire logic                 long_range,
   input  wire logic [CNT_W-1:0]     width_cyc,
   input  wire logic [CNT_W-1:0]     rec_short_cyc,
   input  wire logic [CNT_W-1:0]     rec_long_cyc,
   output logic                      active,
   output logic                      busy
);
   typedef struct packed {
      ssd_phase_t        phase;
      logic [CNT_W-1:0]  cnt;
      logic              act;
   } ssd_pt_t;

   ssd_pt_t st_reg;
   ssd_pt_t st_next;

   // Phase sequencing; a trigger while busy is ignored.
   always_comb begin
      st_next = st_reg;
      unique case (st_reg.phase)
         SSD_IDLE: begin
            if (trigger) begin
               st_next.phase = SSD_PULSE;
               st_next.cnt   = width_cyc - CNT_W'(1);
               st_next.act   = 1'b1;
            end
         end
         SSD_PULSE: begin
            if (st_reg.cnt == '0) begin
               st_next.phase = SSD_RECOVER;
               st_next.act   = 1'b0;
               st_next.cnt   = (long_range ? rec_long_cyc : rec_short_cyc) - CNT_W'(1);
            end else begin
               st_next.cnt = st_reg.cnt - CNT_W'(1);
            end
         end
         SSD_RECOVER: begin
            if (st_reg.cnt == '0) begin
               st_next.phase = SSD_IDLE;
            end else begin
               st_next.cnt = st_reg.cnt - CNT_W'(1);
            end
         end
         default: begin
            st_next.phase = SSD_IDLE;
            st_next.act   = 1'b0;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '{phase: SSD_IDLE, cnt: '0, act: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign active = st_reg.act;
   assign busy   = (st_reg.phase != SSD_IDLE);
endmodule : ssd_point

// ==== ssd_driver.sv ====
// Top of the sixteen-point single-shot driver output block.
`timescale 1ns/1ps

// Contract
// - Sixteen points each have their own single-shot timer and independent width.
// - A written word triggers every point whose bit is one; a point that is still busy ignores the word.
// - In the short range the width may be set from 0.5 ms to 80 ms.
// - When the range option is set the width may be set from 80 ms to 2 s.
// - Every point's width defaults to 60 ms; a point in the long range clamps that default up to 80 ms.
// - After each pulse a recovery of 0.05 ms (short) or 2 ms (long) is held.
// - Range and width are held separately per point.
// - A point sinks current only while its pulse is active.
module ssd_driver
   import ssd_pkg::*;
#(
   parameter int     NPTS          = ssd_pkg::NUM_POINTS,
   parameter longint CYC_SHORT_MIN = ssd_pkg::SHORT_MIN_CYC,
   parameter longint CYC_SHORT_MAX = ssd_pkg::SHORT_MAX_CYC,
   parameter longint CYC_LONG_MIN  = ssd_pkg::LONG_MIN_CYC,
   parameter longint CYC_LONG_MAX  = ssd_pkg::LONG_MAX_CYC,
   parameter longint CYC_DEFAULT   = ssd_pkg::DEFAULT_CYC,
   parameter longint CYC_REC_SHORT = ssd_pkg::REC_SHORT_CYC,
   parameter longint CYC_REC_LONG  = ssd_pkg::REC_LONG_CYC
)
(
   input  wire logic                          CLK,
   input  wire logic                          RST,
   input  wire logic                          WRITE_STB,
   input  wire logic [NPTS-1:0]               WRITE_DATA,
   input  wire logic [NPTS-1:0]               RANGE_LONG,
   input  wire logic                          SET_STB,
   input  wire logic [$clog2(NPTS)-1:0]       SET_POINT,
   input  wire logic [ssd_pkg::CNT_W-1:0]     SET_WIDTH,
   output logic      [NPTS-1:0]               SINK_OE,
   output logic      [NPTS-1:0]               SINK_O,
   output logic      [NPTS-1:0]               BUSY
);
   import ssd_pkg::*;

   // Counts cut to the counter width; a count of 2^29 cycles or more would wrap.
   localparam logic [CNT_W-1:0] W_DEF  = CNT_W'(CYC_DEFAULT);
   localparam logic [CNT_W-1:0] S_MIN  = CNT_W'(CYC_SHORT_MIN);
   localparam logic [CNT_W-1:0] S_MAX  = CNT_W'(CYC_SHORT_MAX);
   localparam logic [CNT_W-1:0] L_MIN  = CNT_W'(CYC_LONG_MIN);
   localparam logic [CNT_W-1:0] L_MAX  = CNT_W'(CYC_LONG_MAX);
   localparam logic [CNT_W-1:0] R_S    = CNT_W'(CYC_REC_SHORT);
   localparam logic [CNT_W-1:0] R_L    = CNT_W'(CYC_REC_LONG);

   // Lowest width that the given range allows.
   function automatic logic [CNT_W-1:0] range_lo(input logic lng);
      if (lng) begin
         range_lo = L_MIN;
      end else begin
         range_lo = S_MIN;
      end
   endfunction : range_lo

   // Highest width that the given range allows.
   function automatic logic [CNT_W-1:0] range_hi(input logic lng);
      if (lng) begin
         range_hi = L_MAX;
      end else begin
         range_hi = S_MAX;
      end
   endfunction : range_hi

   // Clamp a requested width into the range the point is set to.
   function automatic logic [CNT_W-1:0] clamp_width(input logic [CNT_W-1:0] w,
                                                    input logic             lng);
      if (w < range_lo(lng)) begin
         clamp_width = range_lo(lng);
      end else if (w > range_hi(lng)) begin
         clamp_width = range_hi(lng);
      end else begin
         clamp_width = w;
      end
   endfunction : clamp_width

   // State of the block outside the point timers: widths, range synchroniser, trigger pulse and outputs.
   typedef struct packed {
      logic [NPTS-1:0][CNT_W-1:0] width;
      logic [NPTS-1:0]            range_meta;
      logic [NPTS-1:0]            range_sync;
      logic [NPTS-1:0]            trig;
      logic [NPTS-1:0]            out;
      logic [NPTS-1:0]            busy;
   } ssd_top_t;

   ssd_top_t         st_reg;
   ssd_top_t         st_next;
   logic [NPTS-1:0]  act_w;
   logic [NPTS-1:0]  busy_w;
   logic [CNT_W-1:0] width_eff [NPTS];

   // Width store, range synchroniser, trigger pulse and output registers.
   always_comb begin
      st_next            = st_reg;
      st_next.range_meta = RANGE_LONG;
      st_next.range_sync = st_reg.range_meta;
      st_next.trig       = WRITE_STB ? WRITE_DATA : '0;
      if (SET_STB) begin
         st_next.width[SET_POINT] = SET_WIDTH;
      end
      st_next.out        = act_w;
      st_next.busy       = busy_w;
   end

   // State register; every width starts at the default, jumpers read short until synchronised.
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_reg.width      <= {NPTS{W_DEF}};
         st_reg.range_meta <= '0;
         st_reg.range_sync <= '0;
         st_reg.trig       <= '0;
         st_reg.out        <= '0;
         st_reg.busy       <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // One timer per point, each with its own width and range.
   for (genvar i = 0; i < NPTS; i++) begin : g_pt
      // Width as the point uses it, kept inside the point's range.
      assign width_eff[i] = clamp_width(st_reg.width[i], st_reg.range_sync[i]);
      ssd_point u_pt (
         .clk           (CLK),
         .rst           (RST),
         .trigger       (st_reg.trig[i]),
         .long_range    (st_reg.range_sync[i]),
         .width_cyc     (width_eff[i]),
         .rec_short_cyc (R_S),
         .rec_long_cyc  (R_L),
         .active        (act_w[i]),
         .busy          (busy_w[i])
      );
   end

   // Open collector: enable high sinks the pin low while pulsing.
   assign SINK_OE = st_reg.out;
   assign SINK_O  = '0;
   assign BUSY    = st_reg.busy;
endmodule : ssd_driver

// ==== ssd_drv_sva.sv ====
// Checker of the single-shot driver ports.
`timescale 1ns/1ps
module ssd_drv_sva #(parameter int NPTS = 16) (
   input wire logic            CLK,
   input wire logic            RST,
   input wire logic            WRITE_STB,
   input wire logic [NPTS-1:0] WRITE_DATA,
   input wire logic [NPTS-1:0] SINK_OE,
   input wire logic [NPTS-1:0] SINK_O,
   input wire logic [NPTS-1:0] BUSY
);
   // All checks use the one clock and rest during reset.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   AST_LOW_LEVEL: assert property (SINK_O == '0) else $error("sink level not low");
   AST_OE_IN_BUSY: assert property ((SINK_OE & ~BUSY) == '0) else $error("sink idle");
   AST_CAUSE_LOW: assert property ($rose(SINK_OE[0]) |->
      $past(WRITE_STB, 3) && $past(WRITE_DATA[0], 3)) else $error("point 0 no cause");
   AST_CAUSE_TOP: assert property ($rose(SINK_OE[NPTS-1]) |->
      $past(WRITE_STB, 3) && $past(WRITE_DATA[NPTS-1], 3)) else $error("top no cause");
   AST_START: assert property ($rose(BUSY[0]) |-> $rose(SINK_OE[0])) else $error("start");
   AST_MIN_WIDTH: assert property ($rose(SINK_OE[1]) |=> SINK_OE[1] [*8]) else $error("w");
   AST_REC: assert property ($fell(SINK_OE[0]) |-> BUSY[0] [*8]) else $error("recovery");
   AST_BUSY_END: assert property ($fell(BUSY[0]) |-> !$past(SINK_OE[0], 8)) else $error("e");
   // Main scenarios.
   cover property ($rose(SINK_OE[0]));
   cover property ($fell(BUSY[0]));
   cover property (WRITE_STB && BUSY[0]);
endmodule : ssd_drv_sva
bind ssd_driver ssd_drv_sva #(.NPTS(NPTS)) chk (.CLK(CLK), .RST(RST), .WRITE_STB(WRITE_STB),
   .WRITE_DATA(WRITE_DATA), .SINK_OE(SINK_OE), .SINK_O(SINK_O), .BUSY(BUSY));

// ==== ssd_host.sv ====
// Model of the bus controller that writes trigger words.
`timescale 1ns/1ps
module ssd_host (
   input  wire logic   clk,
   output logic        stb,
   output logic [15:0] data
);
   // The idle bus shows no strobe.
   initial begin
      stb = 1'b0;
      data = 16'h0000;
   end
   // One write, held through the taking edge; callers space retriggers.
   task automatic write(input logic [15:0] word);
      @(posedge clk);
      stb <= 1'b1;
      data <= word;
      @(posedge clk);
      stb <= 1'b0;
      data <= ~word;
   endtask : write
endmodule : ssd_host

// ==== tb.sv ====
// Self-checking testbench of the single-shot driver.
`timescale 1ns/1ps
module tb;
   import ssd_pkg::*;
   // Counts at one five-hundredth of the hardware's, so that the run stays short.
   localparam longint TB_S_MIN = 64'd250;
   localparam longint TB_S_MAX = 64'd40000;
   localparam longint TB_L_MIN = 64'd40000;
   localparam longint TB_L_MAX = 64'd1000000;
   localparam longint TB_DEF   = 64'd30000;
   localparam longint TB_R_S   = 64'd25;
   localparam longint TB_R_L   = 64'd1000;
   logic             CLK = 1'b0;
   logic             RST = 1'b1;
   logic             WRITE_STB;
   logic [15:0]      WRITE_DATA;
   logic [15:0]      RANGE_LONG = 16'h0004;
   logic             SET_STB = 1'b0;
   logic [3:0]       SET_POINT = 4'h0;
   logic [CNT_W-1:0] SET_WIDTH = '0;
   logic [15:0]      SINK_OE, SINK_O, BUSY;
   int               num_errors = 0;
   int               total_checks = 0;
   int               n;
   // Clock of 4 ns.
   always #2 CLK = ~CLK;
   ssd_driver #(.NPTS(16), .CYC_SHORT_MIN(TB_S_MIN), .CYC_SHORT_MAX(TB_S_MAX),
      .CYC_LONG_MIN(TB_L_MIN), .CYC_LONG_MAX(TB_L_MAX), .CYC_DEFAULT(TB_DEF),
      .CYC_REC_SHORT(TB_R_S), .CYC_REC_LONG(TB_R_L))
   uut (.CLK(CLK), .RST(RST), .WRITE_STB(WRITE_STB), .WRITE_DATA(WRITE_DATA),
      .RANGE_LONG(RANGE_LONG), .SET_STB(SET_STB), .SET_POINT(SET_POINT),
      .SET_WIDTH(SET_WIDTH), .SINK_OE(SINK_OE), .SINK_O(SINK_O), .BUSY(BUSY));
   ssd_host host (.clk(CLK), .stb(WRITE_STB), .data(WRITE_DATA));
   // Compares one output word and counts the outcome.
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: word got %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   // Compares one cycle count and counts the outcome.
   task automatic chk_count(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: count got %0d expected %0d", $time, got, exp);
      end
   endtask : chk_count
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up
   // Waits some edges and lets their updates land.
   task automatic edges(input int k);
      repeat (k) @(posedge CLK);
      #1;
   endtask : edges
   // Loads the width of one point.
   task automatic set_width(input logic [3:0] pt, input logic [CNT_W-1:0] w);
      @(posedge CLK);
      SET_STB <= 1'b1;
      SET_POINT <= pt;
      SET_WIDTH <= w;
      @(posedge CLK);
      SET_STB <= 1'b0;
   endtask : set_width
   // Outputs idle after reset and a zero word starts nothing.
   task automatic t_idle;
      edges(1);
      chk_word(SINK_OE, 16'h0000);
      chk_word(SINK_O, 16'h0000);
      chk_word(BUSY, 16'h0000);
      host.write(16'h0000);
      edges(4);
      chk_word(BUSY, 16'h0000);
      $display("t_idle done");
   endtask : t_idle
   // Clamped short pulse, refused retrigger, recovery, long point still pulsing.
   task automatic t_fire;
      set_width(4'h0, 29'h1);
      set_width(4'h2, 29'h1);
      host.write(16'h8007);
      edges(1);
      chk_word(SINK_OE, 16'h0000);
      edges(1);
      chk_word(SINK_OE, 16'h8007);
      host.write(16'h0001);
      edges(0);
      for (n = 0; SINK_OE[0] === 1'b1; n++) edges(1);
      chk_count(n, 32'(TB_S_MIN - 64'd2));
      chk_word(SINK_OE, 16'h8006);
      for (n = 0; BUSY[0] === 1'b1; n++) edges(1);
      chk_count(n, 32'(TB_R_S));
      host.write(16'h0001);
      edges(3);
      chk_word(SINK_OE, 16'h8007);
      $display("t_fire done");
   endtask : t_fire
   // Default width, long clamped width, short width clamped at its top, long recovery.
   task automatic t_long;
      for (n = 0; BUSY !== 16'h0000 && n < 50000; n++) edges(1);
      chk_word(BUSY, 16'h0000);
      set_width(4'h3, 29'h1fffffff);
      host.write(16'h000e);
      edges(2);
      for (n = 0; SINK_OE[1] === 1'b1; n++) edges(1);
      chk_count(n, 32'(TB_DEF));
      chk_word(SINK_OE, 16'h000c);
      while (SINK_OE[2] === 1'b1) begin
         edges(1);
         n++;
      end
      chk_count(n, 32'(TB_L_MIN));
      chk_word(SINK_OE, 16'h0000);
      for (n = 0; BUSY[2] === 1'b1; n++) edges(1);
      chk_count(n, 32'(TB_R_L));
      $display("t_long done");
   endtask : t_long
   // Main sequence.
   initial begin
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      t_idle;
      t_fire;
      t_long;
      wrap_up;
   end
   // Watchdog of 100000 cycles, above the longest path through the tests.
   initial begin
      #400000;
      num_errors++;
      wrap_up;
   end
endmodule : tb
